// file: logic/synth_prog_defs.svh
// constants for the synthesizer divider programming port
`ifndef SYNTH_PROG_DEFS_SVH
`define SYNTH_PROG_DEFS_SVH

// divider word widths and field positions
`define SDP_WORD_W       20
`define SDP_FEAT_W       8
`define SDP_PRE_EN_BIT   19
`define SDP_MAIN_HI      18
`define SDP_MAIN_LO      10
`define SDP_REF_HI       9
`define SDP_REF_LO       4
`define SDP_SWAL_HI      3
`define SDP_SWAL_LO      0
`define SDP_MAIN_W       9
`define SDP_REF_W        6
`define SDP_SWAL_W       4

// hardwired pin widths
`define SDP_DIR_MAIN_W   7
`define SDP_DIR_REF_W    4

// reset values
`define SDP_WORD_RST     20'h00000
`define SDP_FEAT_RST     8'h00

// positions in the synchronised pin vector
`define SDP_PIN_SCLK     0
`define SDP_PIN_SDATA    1
`define SDP_PIN_LOAD_N   2
`define SDP_PIN_FEAT_WR  3
`define SDP_PIN_HOP      4
`define SDP_PIN_M_LO     5
`define SDP_PIN_M_HI     6
`define SDP_PIN_SWAL     7
`define SDP_PIN_DIRECT   8
`define SDP_PIN_SERIAL   9
`define SDP_PIN_FSEL_S   10
`define SDP_PIN_FSEL_P   11
`define SDP_PIN_GATE_N   12
`define SDP_PIN_MON      13
`define SDP_PIN_PRE_EN   14
`define SDP_PIN_DATA_LO  15
`define SDP_PIN_DATA_HI  22
`define SDP_PIN_DSW_LO   23
`define SDP_PIN_DSW_HI   26
`define SDP_PIN_DREF_LO  27
`define SDP_PIN_DREF_HI  30
`define SDP_PIN_DMAIN_LO 31
`define SDP_PIN_DMAIN_HI 37
`define SDP_PIN_W        38

`endif

// file: logic/synth_prog_pkg.sv
// types for the synthesizer divider programming port
package synth_prog_pkg;
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_SERIAL,
		MODE_PARALLEL
	} prog_mode_t;

	function automatic prog_mode_t decode_mode(input logic direct_sel, input logic serial_sel);
		if (direct_sel) begin
			return MODE_DIRECT;
		end else if (serial_sel) begin
			return MODE_SERIAL;
		end
		return MODE_PARALLEL;
	endfunction : decode_mode
endpackage : synth_prog_pkg

// file: logic/pin_sync_if.sv
// carrier between the pin synchroniser and the programming logic
`timescale 1ns/1ps
`include "synth_prog_defs.svh"
interface pin_sync_if;
	logic [`SDP_PIN_W-1:0] raw;
	logic [`SDP_PIN_W-1:0] level;
	logic [`SDP_PIN_W-1:0] rise;

	modport sync_side (input raw, output level, output rise);
	modport user_side (output raw, input level, input rise);
endinterface : pin_sync_if

// file: logic/pin_edge_sync.sv
// two-stage synchroniser and rising-edge finder for the programming pins
`timescale 1ns/1ps
`include "synth_prog_defs.svh"
module pin_edge_sync (
	// clock and reset
	input  wire logic      core_clk_i,
	input  wire logic      rst_b_i,
	// pins in, clean levels and edges out
	pin_sync_if.sync_side  pins
);
	logic [`SDP_PIN_W-1:0] meta_r;
	logic [`SDP_PIN_W-1:0] meta_nxt;
	logic [`SDP_PIN_W-1:0] stable_r;
	logic [`SDP_PIN_W-1:0] stable_nxt;
	logic [`SDP_PIN_W-1:0] prev_r;
	logic [`SDP_PIN_W-1:0] prev_nxt;
	logic [1:0]            fill_r;
	logic [1:0]            fill_nxt;

	// the first stage feeds only the second stage
	always_comb begin
		meta_nxt   = pins.raw;
		stable_nxt = meta_r;
		prev_nxt   = stable_r;
		fill_nxt   = (fill_r == 2'h3) ? fill_r : fill_r + 2'h1;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r   <= '0;
			stable_r <= '0;
			prev_r   <= '0;
			fill_r   <= 2'h0;
		end else begin
			meta_r   <= meta_nxt;
			stable_r <= stable_nxt;
			prev_r   <= prev_nxt;
			fill_r   <= fill_nxt;
		end
	end

	// no edges until all three stages hold real pin samples,
	// so a pin already high at reset release is not taken as a rise
	assign pins.level = stable_r;
	assign pins.rise  = (fill_r == 2'h3) ? (stable_r & ~prev_r) : '0;
endmodule : pin_edge_sync

// file: logic/synth_divider_program_port.sv
// divider and prescaler programming port of an integer-N synthesizer
//
// Overview of operation
// - Serial clock rise shifts data into primary word, or feature bits when write-select high.
// - Serial mode: counters use primary word when source select is 1, else secondary.
// - Parallel mode: counters use primary word when source select is 1, else secondary.
// - Prescaler enable bit low turns prescaler on; high bypasses it.
// - Parallel mode: feature strobe rise captures all eight bus bits.
// - Main-count high strobe rise loads bus bits 3..0 into ref 5..4, main 8..7.
// - Main-count low strobe rise loads bus bits into prescaler enable and main 6..0.
// - Swallow strobe rise loads bus bits into ref 3..0 and swallow 3..0.
// - Hop strobe rise in serial or parallel mode copies primary to secondary.
// - Direct select pin picks direct mode; otherwise serial pin picks serial or parallel.
// - Direct mode takes swallow, main and reference counts straight from pins.
// - Main divider chain output is shown on a monitor output.
// - Shifting only while load enable low; its rise copies primary to secondary.
// - Feature bits act only while their gate input is low.
`timescale 1ns/1ps
`include "synth_prog_defs.svh"
module synth_divider_program_port (
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_b_i,
	// mode selection pins
	input  wire logic                       direct_sel_i,
	input  wire logic                       serial_sel_i,
	input  wire logic                       shift_mode_source_sel_i,
	input  wire logic                       bus_mode_source_sel_i,
	input  wire logic                       feature_bits_gate_n_i,
	// serial interface
	input  wire logic                       serial_clk_i,
	input  wire logic                       serial_data_i,
	input  wire logic                       serial_load_n_i,
	input  wire logic                       feature_write_i,
	// parallel interface
	input  wire logic [7:0]                 bus_data_i,
	input  wire logic                       main_count_low_strobe_i,
	input  wire logic                       main_count_high_strobe_i,
	input  wire logic                       swallow_strobe_i,
	input  wire logic                       hop_strobe_i,
	// hardwired interface
	input  wire logic [`SDP_DIR_REF_W-1:0]  direct_ref_i,
	input  wire logic [`SDP_DIR_MAIN_W-1:0] direct_main_i,
	input  wire logic [`SDP_SWAL_W-1:0]     direct_swallow_i,
	input  wire logic                       direct_prescaler_off_i,
	// divider chain monitor
	input  wire logic                       main_chain_i,
	output logic                            main_divider_monitor_o,
	// counter settings to the datapath
	output logic [`SDP_REF_W-1:0]           ref_count_o,
	output logic [`SDP_MAIN_W-1:0]          main_count_o,
	output logic [`SDP_SWAL_W-1:0]          swallow_count_o,
	output logic                            prescaler_on_o,
	output logic                            prescaler_bypass_o,
	output logic [`SDP_FEAT_W-1:0]          feature_bits_o
);
	pin_sync_if pins ();

	logic [`SDP_WORD_W-1:0] pending_divider_word_r;
	logic [`SDP_WORD_W-1:0] pending_divider_word_nxt;
	logic [`SDP_WORD_W-1:0] held_divider_word_r;
	logic [`SDP_WORD_W-1:0] held_divider_word_nxt;
	logic [`SDP_FEAT_W-1:0] feature_word_r;
	logic [`SDP_FEAT_W-1:0] feature_word_nxt;
	logic [`SDP_WORD_W-1:0] active_word_r;
	logic [`SDP_WORD_W-1:0] active_word_nxt;
	logic [`SDP_FEAT_W-1:0] feature_out_r;
	logic [`SDP_FEAT_W-1:0] feature_out_nxt;
	logic                   monitor_r;
	logic                   monitor_nxt;

	synth_prog_pkg::prog_mode_t mode;
	logic [7:0]                 bus;
	logic                       shift_go;

	// every pin passes two flip-flops before use
	assign pins.raw[`SDP_PIN_SCLK]    = serial_clk_i;
	assign pins.raw[`SDP_PIN_SDATA]   = serial_data_i;
	assign pins.raw[`SDP_PIN_LOAD_N]  = serial_load_n_i;
	assign pins.raw[`SDP_PIN_FEAT_WR] = feature_write_i;
	assign pins.raw[`SDP_PIN_HOP]     = hop_strobe_i;
	assign pins.raw[`SDP_PIN_M_LO]    = main_count_low_strobe_i;
	assign pins.raw[`SDP_PIN_M_HI]    = main_count_high_strobe_i;
	assign pins.raw[`SDP_PIN_SWAL]    = swallow_strobe_i;
	assign pins.raw[`SDP_PIN_DIRECT]  = direct_sel_i;
	assign pins.raw[`SDP_PIN_SERIAL]  = serial_sel_i;
	assign pins.raw[`SDP_PIN_FSEL_S]  = shift_mode_source_sel_i;
	assign pins.raw[`SDP_PIN_FSEL_P]  = bus_mode_source_sel_i;
	assign pins.raw[`SDP_PIN_GATE_N]  = feature_bits_gate_n_i;
	assign pins.raw[`SDP_PIN_MON]     = main_chain_i;
	assign pins.raw[`SDP_PIN_PRE_EN]  = direct_prescaler_off_i;
	assign pins.raw[`SDP_PIN_DATA_HI:`SDP_PIN_DATA_LO]   = bus_data_i;
	assign pins.raw[`SDP_PIN_DSW_HI:`SDP_PIN_DSW_LO]     = direct_swallow_i;
	assign pins.raw[`SDP_PIN_DREF_HI:`SDP_PIN_DREF_LO]   = direct_ref_i;
	assign pins.raw[`SDP_PIN_DMAIN_HI:`SDP_PIN_DMAIN_LO] = direct_main_i;

	pin_edge_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.pins       (pins)
	);

	assign mode = synth_prog_pkg::decode_mode(pins.level[`SDP_PIN_DIRECT],
		pins.level[`SDP_PIN_SERIAL]);
	assign bus  = pins.level[`SDP_PIN_DATA_HI:`SDP_PIN_DATA_LO];
	// shifting only while load enable is low
	assign shift_go = (mode == synth_prog_pkg::MODE_SERIAL) && pins.rise[`SDP_PIN_SCLK]
		&& !pins.level[`SDP_PIN_LOAD_N];

	// primary, secondary and feature registers
	always_comb begin
		pending_divider_word_nxt = pending_divider_word_r;
		held_divider_word_nxt    = held_divider_word_r;
		feature_word_nxt         = feature_word_r;
		case (mode)
			synth_prog_pkg::MODE_SERIAL: begin
				if (shift_go) begin
					// first bit in ends up on top
					if (pins.level[`SDP_PIN_FEAT_WR]) begin
						feature_word_nxt = {feature_word_r[`SDP_FEAT_W-2:0],
							pins.level[`SDP_PIN_SDATA]};
					end else begin
						pending_divider_word_nxt = {pending_divider_word_r[`SDP_WORD_W-2:0],
							pins.level[`SDP_PIN_SDATA]};
					end
				end
				if (pins.rise[`SDP_PIN_HOP] || pins.rise[`SDP_PIN_LOAD_N]) begin
					held_divider_word_nxt = pending_divider_word_r;
				end
			end
			synth_prog_pkg::MODE_PARALLEL: begin
				if (pins.rise[`SDP_PIN_FEAT_WR]) begin
					feature_word_nxt = bus;
				end
				if (pins.rise[`SDP_PIN_M_HI]) begin
					pending_divider_word_nxt[`SDP_REF_LO+5:`SDP_REF_LO+4] = bus[3:2];
					pending_divider_word_nxt[`SDP_MAIN_LO+8:`SDP_MAIN_LO+7] = bus[1:0];
				end
				if (pins.rise[`SDP_PIN_M_LO]) begin
					pending_divider_word_nxt[`SDP_PRE_EN_BIT] = bus[7];
					pending_divider_word_nxt[`SDP_MAIN_LO+6:`SDP_MAIN_LO] = bus[6:0];
				end
				if (pins.rise[`SDP_PIN_SWAL]) begin
					pending_divider_word_nxt[`SDP_REF_LO+3:`SDP_REF_LO] = bus[7:4];
					pending_divider_word_nxt[`SDP_SWAL_HI:`SDP_SWAL_LO] = bus[3:0];
				end
				if (pins.rise[`SDP_PIN_HOP]) begin
					held_divider_word_nxt = pending_divider_word_r;
				end
			end
			default: begin
				// direct mode: all strobes ignored
				pending_divider_word_nxt = pending_divider_word_r;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending_divider_word_r <= `SDP_WORD_RST;
			held_divider_word_r    <= `SDP_WORD_RST;
			feature_word_r         <= `SDP_FEAT_RST;
		end else begin
			pending_divider_word_r <= pending_divider_word_nxt;
			held_divider_word_r    <= held_divider_word_nxt;
			feature_word_r         <= feature_word_nxt;
		end
	end

	// settings presented to the counters
	always_comb begin
		active_word_nxt = held_divider_word_r;
		feature_out_nxt = `SDP_FEAT_RST;
		case (mode)
			synth_prog_pkg::MODE_SERIAL: begin
				active_word_nxt = pins.level[`SDP_PIN_FSEL_S] ? pending_divider_word_r
					: held_divider_word_r;
			end
			synth_prog_pkg::MODE_PARALLEL: begin
				active_word_nxt = pins.level[`SDP_PIN_FSEL_P] ? pending_divider_word_r
					: held_divider_word_r;
			end
			default: begin
				active_word_nxt = `SDP_WORD_RST;
				active_word_nxt[`SDP_PRE_EN_BIT] = pins.level[`SDP_PIN_PRE_EN];
				active_word_nxt[`SDP_MAIN_LO+`SDP_DIR_MAIN_W-1:`SDP_MAIN_LO] =
					pins.level[`SDP_PIN_DMAIN_HI:`SDP_PIN_DMAIN_LO];
				active_word_nxt[`SDP_REF_LO+`SDP_DIR_REF_W-1:`SDP_REF_LO] =
					pins.level[`SDP_PIN_DREF_HI:`SDP_PIN_DREF_LO];
				active_word_nxt[`SDP_SWAL_HI:`SDP_SWAL_LO] =
					pins.level[`SDP_PIN_DSW_HI:`SDP_PIN_DSW_LO];
			end
		endcase
		// feature bits only count outside direct mode with the gate low
		if (mode != synth_prog_pkg::MODE_DIRECT && !pins.level[`SDP_PIN_GATE_N]) begin
			feature_out_nxt = feature_word_r;
		end
		monitor_nxt = pins.level[`SDP_PIN_MON];
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			active_word_r <= `SDP_WORD_RST;
			feature_out_r <= `SDP_FEAT_RST;
			monitor_r     <= 1'b0;
		end else begin
			active_word_r <= active_word_nxt;
			feature_out_r <= feature_out_nxt;
			monitor_r     <= monitor_nxt;
		end
	end

	assign ref_count_o            = active_word_r[`SDP_REF_HI:`SDP_REF_LO];
	assign main_count_o           = active_word_r[`SDP_MAIN_HI:`SDP_MAIN_LO];
	assign swallow_count_o        = active_word_r[`SDP_SWAL_HI:`SDP_SWAL_LO];
	assign prescaler_on_o         = !active_word_r[`SDP_PRE_EN_BIT];
	assign prescaler_bypass_o     = active_word_r[`SDP_PRE_EN_BIT];
	assign feature_bits_o         = feature_out_r;
	assign main_divider_monitor_o = monitor_r;
endmodule : synth_divider_program_port

// file: test/synth_divider_program_port_props.sv
// concurrent checks on the divider programming port
`timescale 1ns/1ps
`include "synth_prog_defs.svh"
module synth_divider_program_port_props (
	input wire logic                       core_clk_i,
	input wire logic                       rst_b_i,
	input wire logic                       direct_sel_i,
	input wire logic                       serial_sel_i,
	input wire logic                       shift_mode_source_sel_i,
	input wire logic                       bus_mode_source_sel_i,
	input wire logic                       feature_bits_gate_n_i,
	input wire logic                       serial_load_n_i,
	input wire logic                       feature_write_i,
	input wire logic                       main_count_low_strobe_i,
	input wire logic                       main_count_high_strobe_i,
	input wire logic                       swallow_strobe_i,
	input wire logic                       hop_strobe_i,
	input wire logic [`SDP_DIR_REF_W-1:0]  direct_ref_i,
	input wire logic [`SDP_DIR_MAIN_W-1:0] direct_main_i,
	input wire logic [`SDP_SWAL_W-1:0]     direct_swallow_i,
	input wire logic                       direct_prescaler_off_i,
	input wire logic                       main_chain_i,
	input wire logic                       main_divider_monitor_o,
	input wire logic [`SDP_REF_W-1:0]      ref_count_o,
	input wire logic [`SDP_MAIN_W-1:0]     main_count_o,
	input wire logic [`SDP_SWAL_W-1:0]     swallow_count_o,
	input wire logic                       prescaler_on_o,
	input wire logic                       prescaler_bypass_o,
	input wire logic [`SDP_FEAT_W-1:0]     feature_bits_o
);
	logic [2:0] up_r;
	logic [2:0] up_nxt;
	wire [19:0] cnt_w  = {prescaler_bypass_o, main_count_o, ref_count_o, swallow_count_o};
	wire        bus_m  = !direct_sel_i && !serial_sel_i;
	wire        sh_m   = !direct_sel_i && serial_sel_i;
	wire        no_stb = !main_count_low_strobe_i && !main_count_high_strobe_i
		&& !swallow_strobe_i;
	// cycles since reset release, saturating, so the monitor check skips reset history
	always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) up_r <= 3'h0;
		else up_r <= up_nxt;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence bus_quiet;
		(bus_m && no_stb && !hop_strobe_i && $stable(bus_mode_source_sel_i))[*8];
	endsequence
	sequence bus_second;
		(bus_m && !bus_mode_source_sel_i && !hop_strobe_i)[*8];
	endsequence
	sequence shift_quiet;
		(sh_m && serial_load_n_i && !hop_strobe_i && $stable(shift_mode_source_sel_i))[*8];
	endsequence
	sequence shift_second;
		(sh_m && !serial_load_n_i && !shift_mode_source_sel_i && !hop_strobe_i)[*8];
	endsequence
	sequence direct_held;
		(direct_sel_i && $stable({direct_ref_i, direct_main_i, direct_swallow_i,
			direct_prescaler_off_i}))[*8];
	endsequence
	a_presc_direct: assert property (direct_held |->
		prescaler_on_o == !direct_prescaler_off_i)
		else $error("prescaler enable does not follow the direct pin");
	a_monitor_lag: assert property (up_r == 3'h7 |->
		main_divider_monitor_o == $past(main_chain_i, 3))
		else $error("monitor output does not follow the divider chain");
	a_direct_pins: assert property (direct_held |->
		cnt_w == {direct_prescaler_off_i, 2'b00, direct_main_i, 2'b00, direct_ref_i,
		direct_swallow_i} && feature_bits_o == 8'h00)
		else $error("direct mode counts differ from pins");
	a_feat_gate: assert property (feature_bits_gate_n_i [*8] |-> feature_bits_o == 8'h00)
		else $error("feature bits active while gated off");
	a_feat_hold: assert property (
		(!direct_sel_i && !feature_write_i && $stable(feature_bits_gate_n_i))[*8]
		|-> $stable(feature_bits_o))
		else $error("feature bits changed without a write");
	a_bus_quiet: assert property (bus_quiet |-> $stable(cnt_w))
		else $error("counts changed without a bus strobe");
	a_bus_second: assert property (bus_second |-> $stable(cnt_w))
		else $error("secondary word changed without hop");
	a_shift_quiet: assert property (shift_quiet |-> $stable(cnt_w))
		else $error("counts changed while serial load is high");
	a_shift_second: assert property (shift_second |-> $stable(cnt_w))
		else $error("secondary word changed during shifting");
endmodule : synth_divider_program_port_props

bind synth_divider_program_port synth_divider_program_port_props i_props (.*);

// file: test/serial_host_model.sv
// host model driving the serial programming pins
`timescale 1ns/1ps
module serial_host_model (
	// clock
	input  wire logic core_clk_i,
	// serial pins
	output logic      serial_clk_o,
	output logic      serial_data_o,
	output logic      serial_load_n_o
);
	initial begin
		serial_clk_o = 1'b0;
		serial_data_o = 1'b0;
		serial_load_n_o = 1'b1;
	end
	// one bit per 160 ns; data moves only while the clock is low
	task automatic put_bit(input logic b);
		serial_data_o <= b;
		repeat (4) @(posedge core_clk_i);
		serial_clk_o <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		serial_clk_o <= 1'b0;
	endtask : put_bit
	task automatic shift_word(input logic [19:0] w, input logic open_load);
		if (open_load) serial_load_n_o <= 1'b0;
		for (int i = 19; i >= 0; i--) put_bit(w[i]);
		serial_data_o <= ~w[0];
	endtask : shift_word
	task automatic shift_feat(input logic [7:0] f);
		serial_load_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--) put_bit(f[i]);
		serial_data_o <= ~f[0];
	endtask : shift_feat
	task automatic latch;
		@(posedge core_clk_i);
		serial_load_n_o <= 1'b1;
	endtask : latch
endmodule : serial_host_model

// file: test/synth_divider_program_port_test.sv
// self-checking bench for the divider programming port
`timescale 1ns/1ps
`include "synth_prog_defs.svh"
module synth_divider_program_port_test;
	localparam logic [19:0] P_WORD = {1'b1, 9'h1d5, 6'h29, 4'hc};
	localparam logic [19:0] S_WORD = 20'h5a3c7;
	logic core_clk_i = 1'b0, rst_b_i = 1'b0, direct_sel_i = 1'b0, serial_sel_i = 1'b0;
	logic shift_mode_source_sel_i = 1'b0, bus_mode_source_sel_i = 1'b0;
	logic feature_bits_gate_n_i = 1'b0, direct_prescaler_off_i = 1'b0, main_chain_i = 1'b0;
	logic [4:0] stb = 5'h00;
	logic [7:0] bus_data_i = 8'h00;
	logic [3:0] direct_ref_i = 4'h0, direct_swallow_i = 4'h0;
	logic [6:0] direct_main_i = 7'h00;
	logic serial_clk_i, serial_data_i, serial_load_n_i, main_divider_monitor_o;
	logic prescaler_on_o, prescaler_bypass_o;
	logic [5:0] ref_count_o;
	logic [8:0] main_count_o;
	logic [3:0] swallow_count_o;
	logic [7:0] feature_bits_o;
	wire main_count_low_strobe_i = stb[0];
	wire main_count_high_strobe_i = stb[1];
	wire swallow_strobe_i = stb[2];
	wire hop_strobe_i = stb[3];
	wire feature_write_i = stb[4];
	int fail_count = 0, n_tests = 0, cycles = 0;
	synth_divider_program_port i_dut (.*);
	serial_host_model i_host (.core_clk_i(core_clk_i), .serial_clk_o(serial_clk_i),
		.serial_data_o(serial_data_i), .serial_load_n_o(serial_load_n_i));
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles % 5 == 0) main_chain_i <= ~main_chain_i;
		if (cycles == 4000) begin
			fail_count = fail_count + 1;
			results;
		end
	end
	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic chk_cnt(input logic [19:0] exp);
		cmp({prescaler_bypass_o, main_count_o, ref_count_o, swallow_count_o}, exp);
		cmp({19'h00000, prescaler_on_o}, {19'h00000, ~exp[19]});
	endtask : chk_cnt
	task automatic chk_mon(input logic exp);
		cmp({19'h00000, main_divider_monitor_o}, {19'h00000, exp});
	endtask : chk_mon
	// the chain pin reaches the monitor after two sync stages and one output register
	task automatic t_monitor;
		logic m;
		repeat (12) begin
			@(negedge core_clk_i);
			m = main_chain_i;
			repeat (3) @(negedge core_clk_i);
			chk_mon(m);
		end
	endtask : t_monitor
	task automatic chk_feat(input logic [7:0] exp);
		cmp({12'h000, feature_bits_o}, {12'h000, exp});
	endtask : chk_feat
	task automatic settle;
		repeat (8) @(posedge core_clk_i);
	endtask : settle
	task automatic pulse(input int k, input logic [7:0] d);
		@(posedge core_clk_i);
		bus_data_i <= d;
		repeat (3) @(posedge core_clk_i);
		stb[k] <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		stb[k] <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask : pulse
	task automatic t_bus;
		pulse(0, 8'hd5);
		pulse(1, 8'h0b);
		pulse(2, 8'h9c);
		settle;
		chk_cnt(20'h00000);
		bus_mode_source_sel_i <= 1'b1;
		settle;
		chk_cnt(P_WORD);
		bus_mode_source_sel_i <= 1'b0;
		pulse(3, 8'h00);
		settle;
		chk_cnt(P_WORD);
		pulse(4, 8'ha6);
		settle;
		chk_feat(8'ha6);
		feature_bits_gate_n_i <= 1'b1;
		settle;
		chk_feat(8'h00);
		feature_bits_gate_n_i <= 1'b0;
	endtask : t_bus
	task automatic t_serial;
		serial_sel_i <= 1'b1;
		shift_mode_source_sel_i <= 1'b1;
		pulse(0, 8'h00);
		pulse(2, 8'h00);
		settle;
		chk_cnt(P_WORD);
		shift_mode_source_sel_i <= 1'b0;
		i_host.shift_word(S_WORD, 1'b1);
		settle;
		chk_cnt(P_WORD);
		shift_mode_source_sel_i <= 1'b1;
		settle;
		chk_cnt(S_WORD);
		i_host.latch;
		shift_mode_source_sel_i <= 1'b0;
		settle;
		chk_cnt(S_WORD);
		shift_mode_source_sel_i <= 1'b1;
		i_host.shift_word(20'hfffff, 1'b0);
		settle;
		chk_cnt(S_WORD);
		stb[4] <= 1'b1;
		i_host.shift_feat(8'h3e);
		stb[4] <= 1'b0;
		settle;
		chk_feat(8'h3e);
		chk_cnt(S_WORD);
		// hop in serial mode, then leave primary and secondary different
		i_host.shift_word(P_WORD, 1'b1);
		shift_mode_source_sel_i <= 1'b0;
		pulse(3, 8'h00);
		settle;
		chk_cnt(P_WORD);
		i_host.shift_word(S_WORD, 1'b1);
		settle;
		chk_cnt(P_WORD);
	endtask : t_serial
	task automatic t_direct;
		direct_ref_i <= 4'ha;
		direct_main_i <= 7'h5b;
		direct_swallow_i <= 4'h6;
		direct_prescaler_off_i <= 1'b1;
		direct_sel_i <= 1'b1;
		settle;
		chk_cnt({1'b1, 9'h05b, 6'h0a, 4'h6});
		chk_feat(8'h00);
		direct_swallow_i <= 4'h9;
		direct_prescaler_off_i <= 1'b0;
		settle;
		chk_cnt({1'b0, 9'h05b, 6'h0a, 4'h9});
		// shifting and hop in direct mode must leave both words alone
		i_host.shift_word(20'h00000, 1'b1);
		pulse(3, 8'h00);
		settle;
		chk_cnt({1'b0, 9'h05b, 6'h0a, 4'h9});
		direct_sel_i <= 1'b0;
		serial_sel_i <= 1'b0;
		settle;
		chk_cnt(P_WORD);
		bus_mode_source_sel_i <= 1'b1;
		settle;
		chk_cnt(S_WORD);
		bus_mode_source_sel_i <= 1'b0;
	endtask : t_direct
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		settle;
		chk_cnt(20'h00000);
		t_monitor;
		t_bus;
		t_serial;
		t_direct;
		results;
	end
endmodule : synth_divider_program_port_test
